// ---- epm_core_model.sv ----
// Purpose: behavioural core facing the exception priority map
// Assumes: one done pulse per request, handler returns after six cycles
// Notes:   slow_i stretches fetch, push and unstack answers from one to three cycles
`timescale 1ns/1ps
`default_nettype none
module epm_core_model
  import epm_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          rstn_i,
  input  wire epm_core_req_t req_i,
  input  wire logic          slow_i,
  output epm_core_rsp_t      rsp_o
);
  logic [3:0] f_cnt, p_cnt, u_cnt, h_cnt, lat;
  logic       sp_q, booted;
  assign lat = slow_i ? 4'h3 : 4'h1;
  // saturate so a held request is answered once only
  function automatic logic [3:0] sat(input logic [3:0] c);
    return c + {3'h0, c != 4'hF};
  endfunction
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {f_cnt, p_cnt, u_cnt, h_cnt} <= '0;
      {sp_q, booted} <= 2'b10;
      rsp_o <= '0;
    end else begin
      sp_q <= req_i.sp_load;
      // fetch restarts when the stack-top phase hands over to the reset vector
      f_cnt <= (req_i.fetch && sp_q == req_i.sp_load) ? sat(f_cnt) : 4'h0;
      p_cnt <= req_i.push ? sat(p_cnt) : 4'h0;
      u_cnt <= req_i.unstack ? sat(u_cnt) : 4'h0;
      h_cnt <= (req_i.handler_mode && !req_i.fetch && !req_i.push && !req_i.unstack) ?
               sat(h_cnt) : 4'h0;
      rsp_o.vec_done <= req_i.fetch && sp_q == req_i.sp_load && f_cnt == lat;
      rsp_o.push_done <= req_i.push && p_cnt == lat;
      rsp_o.unstack_done <= req_i.unstack && u_cnt == lat;
      rsp_o.exc_return <= h_cnt == 4'h6;
      rsp_o.first_instr <= !booted && !req_i.fetch && !req_i.sp_load;
      booted <= booted || (!req_i.fetch && !req_i.sp_load);
    end
  end
endmodule
`default_nettype wire

// ---- epm_exception_priority_map.sv ----
// Purpose: rank pending exceptions and sequence entry, nesting and return
// Assumes: core answers each request with a one-cycle done pulse
// Notes:   escalation to hard fault is decided in the cycle of the fault
`timescale 1ns/1ps
`default_nettype none

// How it works
// - eight levels for system handlers and 30 valid lines
// - settable zero ranks below reset, NMI, hard fault
// - all priority fields reset to zero
// - equal priority: lower position wins
// - reset highest, drops to base at first instruction
// - stack top fetched from entry 0 first
// - NMI at 2, only reset blocks it
// - NMI pended only by software write
// - blocked or disabled faults escalate to hard fault, except a blocked imprecise bus fault, which pends at 5
// - protection_unit mismatch pends position 4
// - bus fault at 5, enableable, precise or imprecise
// - usage fault at 6 on undefined or illegal
// - supervisor_call at 11 on service_call_instruction
// - debug monitor at 12 when enabled, not halting
// - pendable_service at 14, software pended only
// - system_tick_timer at 15 when tick fires
// - peripheral lines at 16 up, synchronised in
// - peripheral bit map fixed per source
// - reserved positions never pend
// - enable gates lines, priority fields rank them
// - only preemption part decides nesting
// - state push runs beside vector fetch
// - tail chain skips unstack and restack
// - handlers run in handler mode
module epm_exception_priority_map
  import epm_pkg::*;
#(
  parameter int NEST_DEPTH = 11
) (
  input  wire logic                core_clk_i,
  input  wire logic                rstn_i,
  input  wire logic [NUM_IRQ-1:0]  irq_i,
  input  wire logic [NUM_IRQ-1:0]  en_set_i,
  input  wire logic [NUM_IRQ-1:0]  en_clr_i,
  input  wire logic                prio_wr_i,
  input  wire logic [POS_W-1:0]    prio_wr_pos_i,
  input  wire logic [PRIO_W-1:0]   prio_wr_val_i,
  input  wire logic [1:0]          sub_bits_i,
  input  wire logic                nmi_set_i,
  input  wire logic                pend_srv_set_i,
  input  wire logic                tick_fire_i,
  input  wire logic                sup_call_i,
  input  wire logic                busfault_en_i,
  input  wire logic                dbgmon_req_i,
  input  wire logic                dbgmon_en_i,
  input  wire logic                halting_i,
  input  wire epm_fault_t          faults_i,
  input  wire epm_core_rsp_t       rsp_i,
  output epm_core_req_t            req_o,
  output logic [POS_W-1:0]         vec_idx_o,
  output logic [POS_W-1:0]         active_pos_o,
  output logic [EXT_W-1:0]         exec_prio_o,
  output logic [NUM_POS-1:0]       pending_o,
  output logic [NUM_IRQ-1:0]       irq_en_o
);

  epm_state_t                   state;
  logic [POS_W-1:0]             cur_pos;
  logic [EXT_W-1:0]             cur_pre;
  logic                         tail_q;
  logic                         push_done_q;
  logic                         vec_done_q;
  logic [NUM_POS-1:0][PRIO_W-1:0] prio_q;
  logic [NUM_IRQ-1:0]           irq_en;
  logic [NUM_POS-1:0]           pend_q;
  logic [NUM_IRQ-1:0]           irq_s1;
  logic [NUM_IRQ-1:0]           irq_s2;
  logic [NUM_IRQ-1:0]           irq_s3;
  logic [NUM_IRQ-1:0]           irq_lvl;
  logic [EXT_W-1:0]             act_pre [NEST_DEPTH];
  logic [POS_W-1:0]             act_pos [NEST_DEPTH];
  logic [DEPTH_W-1:0]           depth;
  logic [NUM_POS-1:0][EXT_W-1:0] ext_full;
  logic [NUM_POS-1:0][EXT_W-1:0] ext_pre;
  logic [PRIO_W-1:0]            grp_mask;
  logic [NUM_POS-1:0]           cand;
  logic [NUM_POS-1:0]           set_vec;
  logic [NUM_POS-1:0]           clr_vec;
  logic                         best_valid;
  logic [POS_W-1:0]             best_pos;
  logic [EXT_W-1:0]             best_ext;
  logic [EXT_W-1:0]             best_pre;
  logic [EXT_W-1:0]             exec_prio;
  logic [EXT_W-1:0]             ret_prio;
  logic                         entry_done;
  logic                         can_nest;
  logic                         mem_blk;
  logic                         bus_blk;
  logic                         use_blk;
  logic                         tie_lower;

  localparam logic [DEPTH_W-1:0] DEPTH_ONE = 4'h1;

  function automatic logic [EXT_W-1:0] prio_ext(
    input logic [POS_W-1:0]  pos,
    input logic [PRIO_W-1:0] prio,
    input logic [PRIO_W-1:0] mask
  );
    if (pos == POS_RESET) begin
      return EXT_RESET;
    end
    if (pos == POS_NMI) begin
      return EXT_NMI;
    end
    if (pos == POS_HARD) begin
      return EXT_HARD;
    end
    return {1'b0, prio & mask} + EXT_SETTABLE;
  endfunction

  // subpriority bits drop out of the nesting comparison
  assign grp_mask = PRIO_FULL << sub_bits_i;

  // per position: full rank for selection, masked rank for nesting
  for (genvar p = 0; p < NUM_POS; p++) begin : g_rank
    assign ext_full[p] = prio_ext(POS_W'(p), prio_q[p], PRIO_FULL);
    assign ext_pre[p]  = prio_ext(POS_W'(p), prio_q[p], grp_mask);
  end

  // lines are asynchronous; a change counts once stages two and three agree
  for (genvar i = 0; i < NUM_IRQ; i++) begin : g_sync
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        irq_s1[i]  <= 1'b0;
        irq_s2[i]  <= 1'b0;
        irq_s3[i]  <= 1'b0;
        irq_lvl[i] <= 1'b0;
      end else begin
        irq_s1[i] <= irq_i[i];
        irq_s2[i] <= irq_s1[i];
        irq_s3[i] <= irq_s2[i];
        if (irq_s2[i] == irq_s3[i]) begin
          irq_lvl[i] <= irq_s3[i];
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prio_q <= {NUM_POS{PRIO_RST_VAL}};
    end else if (prio_wr_i && state != EPM_RST_SP && state != EPM_RST_VEC &&
                 prio_wr_pos_i <= POS_LAST && POS_SETTABLE[prio_wr_pos_i]) begin
      prio_q[prio_wr_pos_i] <= prio_wr_val_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_en <= '0;
    end else begin
      irq_en <= (irq_en | en_set_i) & ~en_clr_i & IRQ_VALID_MASK;
    end
  end

  always_comb begin
    if (state == EPM_RST_SP || state == EPM_RST_VEC || state == EPM_RST_RUN) begin
      exec_prio = EXT_RESET;
    end else if (depth == '0) begin
      exec_prio = EXT_BASE;
    end else begin
      exec_prio = act_pre[depth - DEPTH_ONE];
    end
  end

  always_comb begin
    if (depth > DEPTH_ONE) begin
      ret_prio = act_pre[depth - 4'h2];
    end else begin
      ret_prio = EXT_BASE;
    end
  end

  // a fault, other than an enabled imprecise bus fault, that cannot outrank the running level goes to hard fault
  assign mem_blk = ext_pre[POS_MEM] >= exec_prio;
  assign bus_blk = !busfault_en_i || ext_pre[POS_BUS] >= exec_prio;
  assign use_blk = ext_pre[POS_USAGE] >= exec_prio;

  always_comb begin
    set_vec = '0;
    set_vec[NUM_POS-1:POS_IRQ_BASE] = irq_lvl & irq_en & IRQ_VALID_MASK;
    set_vec[POS_NMI]     = nmi_set_i;
    set_vec[POS_PEND_SRV] = pend_srv_set_i;
    set_vec[POS_TICK]     = tick_fire_i;
    set_vec[POS_SUP_CALL] = sup_call_i;
    set_vec[POS_DBG]     = dbgmon_req_i && dbgmon_en_i && !halting_i;
    set_vec[POS_MEM]     = faults_i.prot_mismatch && !mem_blk;
    set_vec[POS_BUS]     = (faults_i.bus_precise && !bus_blk) ||
                           (faults_i.bus_imprecise && busfault_en_i);
    set_vec[POS_USAGE]   = (faults_i.undef_instr || faults_i.illegal_state) &&
                           !use_blk;
    set_vec[POS_HARD]    = (faults_i.prot_mismatch && mem_blk) ||
                           (faults_i.bus_precise && bus_blk) ||
                           (faults_i.bus_imprecise && !busfault_en_i) ||
                           ((faults_i.undef_instr || faults_i.illegal_state) &&
                            use_blk);
  end

  assign clr_vec = entry_done ? ({{(NUM_POS-1){1'b0}}, 1'b1} << cur_pos) : '0;

  // a new event in the clearing cycle stays pending
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pend_q <= '0;
    end else begin
      pend_q <= ((pend_q & ~clr_vec) | set_vec) & POS_VALID_MASK;
    end
  end

  // a line disabled after pending waits without activating
  assign cand = pend_q & {irq_en, 16'hFFFF};

  always_comb begin
    best_valid = 1'b0;
    best_pos   = POS_STACK_TOP;
    best_ext   = EXT_BASE;
    for (int p = 0; p < NUM_POS; p++) begin
      // strict compare in rising order keeps the lower position on a tie
      if (cand[p] && (!best_valid || ext_full[p] < best_ext)) begin
        best_valid = 1'b1;
        best_pos   = POS_W'(p);
        best_ext   = ext_full[p];
      end
    end
  end

  assign best_pre = ext_pre[best_pos];
  assign can_nest = depth < DEPTH_W'(NEST_DEPTH);

  assign entry_done = state == EPM_ENTRY &&
                      (tail_q || push_done_q || rsp_i.push_done) &&
                      (vec_done_q || rsp_i.vec_done);

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state   <= EPM_RST_SP;
      cur_pos <= POS_STACK_TOP;
      cur_pre <= EXT_RESET;
      tail_q  <= 1'b0;
    end else begin
      unique case (state)
        EPM_RST_SP: begin
          if (rsp_i.vec_done) begin
            state   <= EPM_RST_VEC;
            cur_pos <= POS_RESET;
          end
        end
        EPM_RST_VEC: begin
          if (rsp_i.vec_done) begin
            state <= EPM_RST_RUN;
          end
        end
        EPM_RST_RUN: begin
          if (rsp_i.first_instr) begin
            state <= EPM_THREAD;
          end
        end
        EPM_THREAD: begin
          if (best_valid && best_pre < exec_prio) begin
            state   <= EPM_ENTRY;
            cur_pos <= best_pos;
            cur_pre <= best_pre;
            tail_q  <= 1'b0;
          end
        end
        EPM_ENTRY: begin
          if (entry_done) begin
            state <= EPM_HANDLER;
          end
        end
        EPM_HANDLER: begin
          if (rsp_i.exc_return) begin
            if (best_valid && best_pre < ret_prio) begin
              state   <= EPM_ENTRY;
              cur_pos <= best_pos;
              cur_pre <= best_pre;
              tail_q  <= 1'b1;
            end else begin
              state <= EPM_EXIT;
            end
          end else if (best_valid && best_pre < exec_prio && can_nest) begin
            state   <= EPM_ENTRY;
            cur_pos <= best_pos;
            cur_pre <= best_pre;
            tail_q  <= 1'b0;
          end
        end
        EPM_EXIT: begin
          if (rsp_i.unstack_done) begin
            state <= (depth == '0) ? EPM_THREAD : EPM_HANDLER;
          end
        end
        default: begin
          state <= EPM_THREAD;
        end
      endcase
    end
  end

  // done pulses may come in either order, so each is remembered
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      push_done_q <= 1'b0;
      vec_done_q  <= 1'b0;
    end else if (state != EPM_ENTRY || entry_done) begin
      push_done_q <= 1'b0;
      vec_done_q  <= 1'b0;
    end else begin
      push_done_q <= push_done_q || rsp_i.push_done;
      vec_done_q  <= vec_done_q || rsp_i.vec_done;
    end
  end

  // nesting stack; depth is bounded, deeper preemption waits
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      depth <= '0;
      for (int d = 0; d < NEST_DEPTH; d++) begin
        act_pre[d] <= EXT_BASE;
        act_pos[d] <= POS_STACK_TOP;
      end
    end else if (entry_done) begin
      act_pre[depth] <= cur_pre;
      act_pos[depth] <= cur_pos;
      depth          <= depth + DEPTH_ONE;
    end else if (state == EPM_HANDLER && rsp_i.exc_return) begin
      depth <= depth - DEPTH_ONE;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      exec_prio_o  <= EXT_RESET;
      active_pos_o <= POS_STACK_TOP;
    end else begin
      exec_prio_o  <= exec_prio;
      active_pos_o <= (depth == '0) ? POS_STACK_TOP : act_pos[depth - DEPTH_ONE];
    end
  end

  always_comb begin
    req_o.fetch        = state == EPM_RST_SP || state == EPM_RST_VEC ||
                         (state == EPM_ENTRY && !vec_done_q);
    req_o.sp_load      = state == EPM_RST_SP;
    req_o.push         = state == EPM_ENTRY && !tail_q && !push_done_q;
    req_o.unstack      = state == EPM_EXIT;
    req_o.tail         = state == EPM_ENTRY && tail_q;
    req_o.handler_mode = depth != '0;
  end

  assign vec_idx_o = cur_pos;
  assign pending_o = pend_q;
  assign irq_en_o  = irq_en;

  // independent tie check for the selector
  always_comb begin
    tie_lower = 1'b0;
    for (int p = 0; p < NUM_POS; p++) begin
      if (cand[p] && ext_full[p] == best_ext && POS_W'(p) < best_pos) begin
        tie_lower = 1'b1;
      end
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  a_prio_reset_zero: assert property (
    (state == EPM_RST_SP) |-> (prio_q == '0))
    else $error("priority field not zero after reset");

  a_stack_top_first: assert property (
    (state == EPM_RST_SP && rsp_i.vec_done) |=>
      (state == EPM_RST_VEC && vec_idx_o == POS_RESET && !req_o.sp_load))
    else $error("reset vector not fetched after stack top");

  a_reset_to_base: assert property (
    (state == EPM_RST_RUN && rsp_i.first_instr) |-> ##2 (exec_prio_o == EXT_BASE))
    else $error("level did not drop to base");

  a_tie_lower_pos: assert property (
    best_valid |-> !tie_lower)
    else $error("tie not broken by lower position");

  a_nmi_wins: assert property (
    cand[POS_NMI] |-> (best_pos == POS_NMI && best_ext == EXT_NMI))
    else $error("nmi not ranked first");

  a_nmi_sw_only: assert property (
    $rose(pend_q[POS_NMI]) |-> $past(nmi_set_i))
    else $error("nmi pended without software write");

  a_fault_escalate: assert property (
    (faults_i.undef_instr && use_blk) |=> pend_q[POS_HARD])
    else $error("blocked usage fault did not escalate");

  a_reserved_quiet: assert property (
    (pend_q & ~POS_VALID_MASK) == '0)
    else $error("reserved position pending");

  a_enable_gate: assert property (
    (pend_q[NUM_POS-1:POS_IRQ_BASE] & ~$past(pend_q[NUM_POS-1:POS_IRQ_BASE]) &
     ~$past(irq_en)) == '0)
    else $error("disabled line became pending");

  a_no_sub_preempt: assert property (
    (state == EPM_HANDLER && !rsp_i.exc_return && best_pre >= exec_prio)
      |=> state != EPM_ENTRY)
    else $error("preempted on subpriority only");

  a_parallel_entry: assert property (
    (state == EPM_ENTRY && $past(state) != EPM_ENTRY && !tail_q)
      |-> (req_o.push && req_o.fetch))
    else $error("push and fetch not started together");

  a_tail_skip: assert property (
    (state == EPM_ENTRY && tail_q) |-> (!req_o.push && !req_o.unstack))
    else $error("tail chain restacked");

  a_handler_mode: assert property (
    (state == EPM_HANDLER) |-> req_o.handler_mode)
    else $error("handler not in handler mode");

endmodule
`default_nettype wire

// ---- epm_pkg.sv ----
// Purpose: shared constants and types for the exception priority map
// Assumes: positions 0..15 are system exceptions, 16.. peripheral lines
// Notes:   extended priority 0 is most urgent; 15 is the base level
package epm_pkg;

  localparam int NUM_IRQ = 35;
  localparam int NUM_POS = 51;
  localparam int POS_W   = 6;
  localparam int PRIO_W  = 3;
  localparam int EXT_W   = 4;
  localparam int DEPTH_W = 4;

  localparam logic [POS_W-1:0] POS_STACK_TOP = 6'h00;
  localparam logic [POS_W-1:0] POS_RESET     = 6'h01;
  localparam logic [POS_W-1:0] POS_NMI       = 6'h02;
  localparam logic [POS_W-1:0] POS_HARD      = 6'h03;
  localparam logic [POS_W-1:0] POS_MEM       = 6'h04;
  localparam logic [POS_W-1:0] POS_BUS       = 6'h05;
  localparam logic [POS_W-1:0] POS_USAGE     = 6'h06;
  localparam logic [POS_W-1:0] POS_SUP_CALL  = 6'h0B;
  localparam logic [POS_W-1:0] POS_DBG       = 6'h0C;
  localparam logic [POS_W-1:0] POS_PEND_SRV  = 6'h0E;
  localparam logic [POS_W-1:0] POS_TICK      = 6'h0F;
  localparam logic [POS_W-1:0] POS_IRQ_BASE  = 6'h10;
  localparam logic [POS_W-1:0] POS_LAST      = 6'h32;

  // peripheral bit numbers within the interrupt lines
  localparam int IRQ_GPIO_A = 0, IRQ_GPIO_E = 4, IRQ_UART0 = 5, IRQ_UART1 = 6;
  localparam int IRQ_SYNC_SERIAL_PORT_0 = 7, IRQ_I2C0 = 8, IRQ_ADC_SEQ0 = 14;
  localparam int IRQ_ADC_SEQ3 = 17, IRQ_WATCHDOG = 18, IRQ_TIMER0_A = 19;
  localparam int IRQ_TIMER2_B = 24, IRQ_COMP0 = 25, IRQ_COMP2 = 27;
  localparam int IRQ_SYS_CTRL = 28, IRQ_FLASH = 29, IRQ_GPIO_F = 30;
  localparam int IRQ_GPIO_H = 32, IRQ_UART2 = 33, IRQ_SYNC_SERIAL_PORT_1 = 34;

  localparam logic [NUM_IRQ-1:0] IRQ_VALID_MASK = 35'h7_FFFF_C1FF;
  localparam logic [NUM_POS-1:0] POS_VALID_MASK = {IRQ_VALID_MASK, 16'hD87C};
  localparam logic [NUM_POS-1:0] POS_SETTABLE   = {IRQ_VALID_MASK, 16'hD870};

  localparam logic [EXT_W-1:0]  EXT_RESET    = 4'h0;
  localparam logic [EXT_W-1:0]  EXT_NMI      = 4'h1;
  localparam logic [EXT_W-1:0]  EXT_HARD     = 4'h2;
  localparam logic [EXT_W-1:0]  EXT_SETTABLE = 4'h3;
  localparam logic [EXT_W-1:0]  EXT_BASE     = 4'hF;
  localparam logic [PRIO_W-1:0] PRIO_RST_VAL = 3'h0;
  localparam logic [PRIO_W-1:0] PRIO_FULL    = 3'h7;

  typedef enum logic [2:0] {
    EPM_RST_SP  = 3'h0,
    EPM_RST_VEC = 3'h1,
    EPM_RST_RUN = 3'h3,
    EPM_THREAD  = 3'h2,
    EPM_ENTRY   = 3'h6,
    EPM_HANDLER = 3'h7,
    EPM_EXIT    = 3'h5
  } epm_state_t;

  typedef struct packed {
    logic prot_mismatch;
    logic bus_precise;
    logic bus_imprecise;
    logic undef_instr;
    logic illegal_state;
  } epm_fault_t;

  typedef struct packed {
    logic push_done;
    logic vec_done;
    logic unstack_done;
    logic exc_return;
    logic first_instr;
  } epm_core_rsp_t;

  typedef struct packed {
    logic fetch;
    logic sp_load;
    logic push;
    logic unstack;
    logic tail;
    logic handler_mode;
  } epm_core_req_t;

endpackage

// ---- tb_exception_priority_map.sv ----
// Purpose: self-checking bench for the exception priority map
// Assumes: entries are judged in order as the active position changes
// Notes:   fixed positions get a write too, which must be ignored
`timescale 1ns/1ps
`default_nettype none
module tb_exception_priority_map;
  import epm_pkg::*;
  logic               core_clk_i = 0, rstn_i = 0, slow = 0, tail_seen = 0;
  logic [NUM_IRQ-1:0] irq_i = '0, en_set_i = '0, en_clr_i = '0;
  logic               prio_wr_i = 0, nmi_set_i = 0, pend_srv_set_i = 0;
  logic               tick_fire_i = 0, sup_call_i = 0, busfault_en_i = 0;
  logic               dbgmon_req_i = 0, dbgmon_en_i = 0, halting_i = 0;
  logic [POS_W-1:0]   prio_wr_pos_i = '0, vec_idx_o, active_pos_o, last_pos = '0;
  logic [PRIO_W-1:0]  prio_wr_val_i = '0, r;
  logic [1:0]         sub_bits_i = '0;
  logic [EXT_W-1:0]   exec_prio_o, e;
  logic [NUM_POS-1:0] pending_o;
  logic [NUM_IRQ-1:0] irq_en_o;
  epm_fault_t         faults_i = '0;
  epm_core_rsp_t      rsp_i;
  epm_core_req_t      req_o;
  logic [9:0]         exp_q[$];
  int                 num_errors = 0, n_tests = 0, i, k;
  localparam logic [5:0] SRC_POS[10] = '{6'h02, 6'h0E, 6'h0F, 6'h0B, 6'h04,
                                         6'h03, 6'h05, 6'h06, 6'h06, 6'h0C};

  epm_exception_priority_map uut (.core_clk_i, .rstn_i, .irq_i, .en_set_i, .en_clr_i,
    .prio_wr_i, .prio_wr_pos_i, .prio_wr_val_i, .sub_bits_i, .nmi_set_i, .pend_srv_set_i,
    .tick_fire_i, .sup_call_i, .busfault_en_i, .dbgmon_req_i, .dbgmon_en_i,
    .halting_i, .faults_i, .rsp_i, .req_o, .vec_idx_o, .active_pos_o, .exec_prio_o,
    .pending_o, .irq_en_o);
  epm_core_model core (.clk_i(core_clk_i), .rstn_i, .req_i(req_o), .slow_i(slow),
    .rsp_o(rsp_i));

  always #12.5 core_clk_i = ~core_clk_i;

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic tk();
    @(posedge core_clk_i);
    #1;
  endtask

  task automatic wait_idle();
    for (i = 0; i < 300; i++) begin
      tk();
      if (active_pos_o === '0 && exp_q.size() == 0 && req_o === '0) break;
    end
    chk("back to thread", 1, i < 300);
    chk("base after return", EXT_BASE, exec_prio_o);
  endtask

  task automatic wr_prio(input logic [5:0] p, input logic [2:0] v);
    @(posedge core_clk_i);
    prio_wr_i <= 1;
    prio_wr_pos_i <= p;
    prio_wr_val_i <= v;
    @(posedge core_clk_i);
    prio_wr_i <= 0;
  endtask

  // three cycles so the synchroniser agrees, gone before the entry clears
  task automatic irq_pulse(input logic [NUM_IRQ-1:0] m);
    @(posedge core_clk_i);
    irq_i <= m;
    repeat (3) @(posedge core_clk_i);
    irq_i <= '0;
  endtask

  task automatic fire(input int s);
    @(posedge core_clk_i);
    case (s)
      0: nmi_set_i <= 1;
      1: pend_srv_set_i <= 1;
      2: tick_fire_i <= 1;
      3: sup_call_i <= 1;
      4: faults_i.prot_mismatch <= 1;
      5: faults_i.bus_precise <= 1;
      6: faults_i.bus_imprecise <= 1;
      7: faults_i.undef_instr <= 1;
      8: faults_i.illegal_state <= 1;
      default: dbgmon_req_i <= 1;
    endcase
    @(posedge core_clk_i);
    {nmi_set_i, pend_srv_set_i, tick_fire_i, sup_call_i, dbgmon_req_i} <= '0;
    faults_i <= '0;
  endtask

  // sampled mid-cycle so the registered outputs have settled
  always @(negedge core_clk_i) begin
    last_pos <= active_pos_o;
    if (req_o.tail === 1'b1) tail_seen <= 1;
    if (rstn_i && active_pos_o !== last_pos && active_pos_o !== '0) begin
      if (exp_q.size() == 0) chk("unexpected entry", 0, {active_pos_o, exec_prio_o});
      else chk("entry pos/prio", exp_q.pop_front(), {active_pos_o, exec_prio_o});
    end
  end

  initial begin
    repeat (20000) @(posedge core_clk_i);
    num_errors++;
    print_verdict();
  end

  initial begin
    void'($urandom(52));
    repeat (3) tk();
    chk("reset vec_idx", 0, vec_idx_o);
    chk("reset sp_load", 1, req_o.sp_load);
    chk("reset prio", EXT_RESET, exec_prio_o);
    chk("reset pending", 0, pending_o);
    repeat (2) @(posedge core_clk_i);
    rstn_i <= 1;
    for (i = 0; i < 20 && vec_idx_o !== 6'h01; i++) tk();
    chk("reset vector after stack top", 2'b01, {req_o.sp_load, req_o.fetch});
    for (i = 0; i < 20 && exec_prio_o !== EXT_BASE; i++) tk();
    chk("base level", EXT_BASE, exec_prio_o);
    $display("test reset done");

    @(posedge core_clk_i);
    en_set_i <= '1;
    en_clr_i <= 35'h0_0000_0004;
    @(posedge core_clk_i);
    en_set_i <= '0;
    en_clr_i <= '0;
    tk();
    chk("enables", IRQ_VALID_MASK & ~35'h0_0000_0004, irq_en_o);
    irq_pulse(35'h0_0000_3E04);
    fire(9);
    repeat (10) tk();
    chk("reserved and gated", 0, pending_o);
    $display("test gating done");

    exp_q.push_back({6'h10, 4'h3});
    exp_q.push_back({6'h11, 4'h3});
    irq_pulse(35'h0_0000_0003);
    wait_idle();
    chk("tail chain", 1, tail_seen);
    r = 3'($urandom_range(7));
    wr_prio(6'h10, r);
    wr_prio(6'h11, r);
    exp_q.push_back({6'h10, EXT_SETTABLE + {1'b0, r}});
    exp_q.push_back({6'h11, EXT_SETTABLE + {1'b0, r}});
    irq_pulse(35'h0_0000_0003);
    wait_idle();
    wr_prio(6'h10, 3'h5);
    wr_prio(6'h11, 3'h2);
    exp_q.push_back({6'h11, 4'h5});
    exp_q.push_back({6'h10, 4'h8});
    irq_pulse(35'h0_0000_0003);
    wait_idle();
    $display("test peripheral ranking done");

    // one subpriority bit: line 16 at 3 and service at 2 share group 2
    sub_bits_i <= 2'h1;
    wr_prio(6'h10, 3'h3);
    wr_prio(POS_PEND_SRV, 3'h2);
    exp_q.push_back({6'h10, 4'h5});
    exp_q.push_back({6'h0E, 4'h5});
    irq_pulse(35'h0_0000_0001);
    for (i = 0; i < 20 && active_pos_o !== 6'h10; i++) tk();
    fire(1);
    wait_idle();
    wr_prio(POS_PEND_SRV, 3'h0);
    exp_q.push_back({6'h10, 4'h5});
    exp_q.push_back({6'h0E, 4'h3});
    exp_q.push_back({6'h10, 4'h5});
    irq_pulse(35'h0_0000_0001);
    for (i = 0; i < 20 && active_pos_o !== 6'h10; i++) tk();
    fire(1);
    wait_idle();
    sub_bits_i <= 2'h0;
    dbgmon_en_i <= 1;
    halting_i <= 1;
    fire(9);
    tk();
    chk("halting drops monitor", 0, pending_o[POS_DBG]);
    halting_i <= 0;
    $display("test preemption groups done");

    slow <= 1;
    dbgmon_en_i <= 1;
    for (k = 0; k < 10; k++) begin
      r = 3'($urandom_range(7));
      wr_prio(SRC_POS[k], r);
      busfault_en_i <= (k == 6);
      e = (SRC_POS[k] == POS_NMI) ? EXT_NMI :
          (SRC_POS[k] == POS_HARD) ? EXT_HARD : EXT_SETTABLE + {1'b0, r};
      exp_q.push_back({SRC_POS[k], e});
      fire(k);
      #1;
      chk("source pending", 1, pending_o[SRC_POS[k]]);
      wait_idle();
      $display("test source %0d done", k);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
